// [hw/ocs_source_select.v]
// output clock source select register bank and divider sync
`include "ocs_consts.vh"
module ocs_source_select (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // register port
    input wire [15:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // clock routing
    output reg [3:0] low_source_out,
    output reg [11:0] high_source_out,
    // divider control
    output reg [7:0] divider_hold_out,
    output reg [7:0] coarse_clear_out,
    output reg [1:0] fine_load_out
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n;
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] sync_and_low_source_select_reg;
    reg [7:0] source_select_outputs_four_five_reg;
    reg [7:0] source_select_outputs_six_seven_reg;
    wire first_loop_divider_sync;
    wire second_loop_divider_sync;
    wire [2:0] out4_source_choice;
    wire [2:0] out5_source_choice;
    wire [2:0] out6_source_choice;
    wire [2:0] out7_source_choice;
    assign first_loop_divider_sync =
        sync_and_low_source_select_reg[`OCS_SYNC0_BIT];
    assign second_loop_divider_sync =
        sync_and_low_source_select_reg[`OCS_SYNC1_BIT];
    assign out4_source_choice =
        source_select_outputs_four_five_reg[`OCS_SEL_A_MSB:`OCS_SEL_A_LSB];
    assign out5_source_choice =
        source_select_outputs_four_five_reg[`OCS_SEL_B_MSB:`OCS_SEL_B_LSB];
    assign out6_source_choice =
        source_select_outputs_six_seven_reg[`OCS_SEL_A_MSB:`OCS_SEL_A_LSB];
    assign out7_source_choice =
        source_select_outputs_six_seven_reg[`OCS_SEL_B_MSB:`OCS_SEL_B_LSB];

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync_and_low_source_select_reg <= `OCS_RST_SYNC_LOW;
            source_select_outputs_four_five_reg <= `OCS_RST_SEL_45;
            source_select_outputs_six_seven_reg <= `OCS_RST_SEL_67;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `OCS_ADDR_SYNC_LOW: begin
                    sync_and_low_source_select_reg <=
                        reg_wdata_in & `OCS_WR_MASK_SYNC_LOW;
                end
                `OCS_ADDR_SEL_45: begin
                    source_select_outputs_four_five_reg <=
                        reg_wdata_in & `OCS_WR_MASK_SEL;
                end
                `OCS_ADDR_SEL_67: begin
                    source_select_outputs_six_seven_reg <=
                        reg_wdata_in & `OCS_WR_MASK_SEL;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // which outputs a loop drives
    // ----------------------------------------
    function loop_drives;
        input [2:0] code;
        input loop_sel;
        input out2_on_loop;
        input out3_on_loop;
        begin
            case (code)
                `OCS_SRC_LOOP0: loop_drives = ~loop_sel;
                `OCS_SRC_LOOP1: loop_drives = loop_sel;
                `OCS_SRC_OUT2: loop_drives = out2_on_loop;
                `OCS_SRC_OUT3: loop_drives = out3_on_loop;
                default: loop_drives = 1'b0;
            endcase
        end
    endfunction

    function [7:0] loop_set;
        input loop_sel;
        input [3:0] low;
        input [11:0] high;
        reg [3:0] lo;
        begin
            lo = loop_sel ? low : ~low;
            loop_set = {
                loop_drives(high[11:9], loop_sel, lo[2], lo[3]),
                loop_drives(high[8:6], loop_sel, lo[2], lo[3]),
                loop_drives(high[5:3], loop_sel, lo[2], lo[3]),
                loop_drives(high[2:0], loop_sel, lo[2], lo[3]),
                lo};
        end
    endfunction

    wire [3:0] low_sel;
    wire [11:0] high_sel;
    wire [7:0] uses_first;
    wire [7:0] uses_second;
    assign low_sel = sync_and_low_source_select_reg[`OCS_SEL_LOW_MSB:0];
    assign high_sel = {out7_source_choice, out6_source_choice,
        out5_source_choice, out4_source_choice};
    assign uses_first = loop_set(1'b0, low_sel, high_sel);
    assign uses_second = loop_set(1'b1, low_sel, high_sel);

    // ----------------------------------------
    // sync control per loop
    // ----------------------------------------
    wire [7:0] hold_first;
    wire [7:0] hold_second;
    wire [7:0] rel_first;
    wire [7:0] rel_second;
    ocs_sync_ctrl u_sync_first (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .sync_in(first_loop_divider_sync),
        .uses_loop_in(uses_first),
        .hold_out(hold_first),
        .release_out(rel_first)
    );
    ocs_sync_ctrl u_sync_second (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .sync_in(second_loop_divider_sync),
        .uses_loop_in(uses_second),
        .hold_out(hold_second),
        .release_out(rel_second)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    reg [7:0] rdata_next;
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr_in)
            `OCS_ADDR_SYNC_LOW: rdata_next = sync_and_low_source_select_reg;
            `OCS_ADDR_SEL_45: rdata_next = source_select_outputs_four_five_reg;
            `OCS_ADDR_SEL_67: rdata_next = source_select_outputs_six_seven_reg;
            `OCS_ADDR_FIXED: rdata_next = `OCS_FIXED_VAL;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
            low_source_out <= 4'h0;
            high_source_out <= 12'h000;
            divider_hold_out <= 8'h00;
            coarse_clear_out <= 8'h00;
            fine_load_out <= 2'b00;
        end else begin
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_next;
            end
            low_source_out <= low_sel;
            high_source_out <= high_sel;
            divider_hold_out <= hold_first | hold_second;
            coarse_clear_out <= rel_first | rel_second;
            fine_load_out <= {
                |rel_second[`OCS_FRAC_MSB:`OCS_FRAC_LSB],
                |rel_first[`OCS_FRAC_MSB:`OCS_FRAC_LSB]};
        end
    end
endmodule // ocs_source_select

// [hw/ocs_consts.vh]
// constants for the output clock source select block
// How it works
// - each sync bit acts only on dividers whose clock comes from its loop, directly or through output 2 or 3.
// - a 0 to 1 sync change holds that loop's dividers in reset while it is 1.
// - a 1 to 0 sync change releases all affected dividers in one cycle.
// - the release clears the coarse phase of the affected outputs to zero.
// - both sync bits reset to 0 so no divider is held after reset.
// - outputs 0 to 3 take the first loop on 0 and the second on 1.
// - outputs 0 and 2 reset to the first loop, 1 and 3 to the second.
// - outputs 4 to 7 use a three-bit code for loops, outputs, refs, crystal.
// - three-bit selectors reset to 000, 010, 110 and 101 for outputs 4 to 7.
// - reserved bits are written as zero and read back undefined (here zero).
// - a new fine phase takes effect only on a toggle of the driving sync bit.
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define OCS_ADDR_W 16
`define OCS_ADDR_SYNC_LOW 16'h00A8
`define OCS_ADDR_SEL_45 16'h00A9
`define OCS_ADDR_SEL_67 16'h00AA
`define OCS_ADDR_FIXED 16'h00AB
// ----------------------------------------
// reset values and fixed patterns
// ----------------------------------------
`define OCS_RST_SYNC_LOW 8'h0A
`define OCS_RST_SEL_45 8'h20
`define OCS_RST_SEL_67 8'h56
`define OCS_FIXED_VAL 8'hA0
// ----------------------------------------
// field positions
// ----------------------------------------
`define OCS_SEL_LOW_MSB 3
`define OCS_SYNC0_BIT 4
`define OCS_SYNC1_BIT 5
`define OCS_SEL_A_MSB 2
`define OCS_SEL_A_LSB 0
`define OCS_SEL_B_MSB 6
`define OCS_SEL_B_LSB 4
`define OCS_FRAC_MSB 3
`define OCS_FRAC_LSB 2
`define OCS_WR_MASK_SYNC_LOW 8'h3F
`define OCS_WR_MASK_SEL 8'h77
// ----------------------------------------
// three-bit source codes
// ----------------------------------------
`define OCS_SRC_LOOP0 3'h0
`define OCS_SRC_LOOP1 3'h1
`define OCS_SRC_OUT2 3'h2
`define OCS_SRC_OUT3 3'h3
`define OCS_SRC_REF0 3'h4
`define OCS_SRC_REF1 3'h5
`define OCS_SRC_REF2 3'h6
`define OCS_SRC_XTAL 3'h7
`endif

// [hw/ocs_sync_ctrl.v]
// per-loop divider hold and release control
module ocs_sync_ctrl (
    // clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // control
    input wire sync_in,
    input wire [7:0] uses_loop_in,
    // status
    output reg [7:0] hold_out,
    output reg [7:0] release_out
);
    reg sync_d_reg;
    wire rise;
    wire fall;
    assign rise = sync_in & ~sync_d_reg;
    assign fall = ~sync_in & sync_d_reg;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_d_reg <= 1'b0;
            hold_out <= 8'h00;
            release_out <= 8'h00;
        end else begin
            sync_d_reg <= sync_in;
            release_out <= 8'h00;
            if (rise) begin
                hold_out <= uses_loop_in;
            end else if (fall) begin
                release_out <= hold_out;
                hold_out <= 8'h00;
            end
        end
    end
endmodule // ocs_sync_ctrl

// [tb/ocs_source_select_assertions.sv]
// checker for the output clock source select block
`include "ocs_consts.vh"
module ocs_source_select_assertions (
    // clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // register port
    input wire [15:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // routing and divider control
    input wire [3:0] low_source_out,
    input wire [11:0] high_source_out,
    input wire [7:0] divider_hold_out,
    input wire [7:0] coarse_clear_out,
    input wire [1:0] fine_load_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_reset_sel_values: assert property ($rose(arst_n_in) |-> ##[1:4]
        (low_source_out == 4'hA && high_source_out == 12'hB90))
        else $error("selector reset values wrong");
    a_low_sel_write: assert property (
        reg_wr_in && reg_addr_in == `OCS_ADDR_SYNC_LOW |-> ##2
        {4'h0, low_source_out} == ($past(reg_wdata_in, 2) & 8'h0F))
        else $error("low selector write wrong");
    a_high_sel_write: assert property (
        reg_wr_in && reg_addr_in == `OCS_ADDR_SEL_45 |-> ##2
        {2'b00, high_source_out[5:3], 1'b0, high_source_out[2:0]}
        == ($past(reg_wdata_in, 2) & 8'h77))
        else $error("high selector wrong");
    a_fixed_read: assert property (
        reg_rd_in && reg_addr_in == `OCS_ADDR_FIXED
        |=> reg_rdata_out == `OCS_FIXED_VAL) else $error("fixed read wrong");
    a_rdata_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_hold_rise_cause: assert property (
        (divider_hold_out & ~$past(divider_hold_out)) != 8'h00 |->
        $past(reg_wr_in, 3) && $past(reg_addr_in, 3) == 16'h00A8)
        else $error("hold rose without sync write");
    a_hold_fall_cause: assert property (
        ($past(divider_hold_out) & ~divider_hold_out) != 8'h00 |->
        $past(reg_wr_in, 3) && $past(reg_addr_in, 3) == 16'h00A8)
        else $error("hold fell without sync write");
    a_clear_on_release: assert property (coarse_clear_out ==
        ($past(divider_hold_out) & ~divider_hold_out))
        else $error("coarse clear not matching release");
    a_fine_with_clear: assert property (fine_load_out != 2'b00 |->
        coarse_clear_out != 8'h00) else $error("fine load without release");
    c_hold: cover property (divider_hold_out != 8'h00);
    c_clear: cover property (coarse_clear_out != 8'h00);
    c_fine: cover property (fine_load_out != 2'b00);
endmodule // ocs_source_select_assertions
bind ocs_source_select ocs_source_select_assertions u_chk (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .low_source_out(low_source_out), .high_source_out(high_source_out),
    .divider_hold_out(divider_hold_out),
    .coarse_clear_out(coarse_clear_out), .fine_load_out(fine_load_out));

// [tb/testbench.sv]
// self-checking bench for the output clock source select block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0;
    logic arst_n_in = 0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 0;
    logic reg_rd_in = 0;
    wire [7:0] reg_rdata_out;
    wire [3:0] low_source_out;
    wire [11:0] high_source_out;
    wire [7:0] divider_hold_out;
    wire [7:0] coarse_clear_out;
    wire [1:0] fine_load_out;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] lowv, s45, s67, set_v;
    logic lp;
    logic [2:0] fast;
    always #10 clk_in = ~clk_in;
    ocs_source_select u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .low_source_out(low_source_out),
        .high_source_out(high_source_out),
        .divider_hold_out(divider_hold_out),
        .coarse_clear_out(coarse_clear_out), .fine_load_out(fine_load_out));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] e,
        input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        @(posedge clk_in);
        @(negedge clk_in);
        reg_wr_in = 0;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_addr_in = a;
        reg_rd_in = 1;
        @(posedge clk_in);
        @(negedge clk_in);
        reg_rd_in = 0;
        chk("rdata", {4'h0, e}, {4'h0, reg_rdata_out});
        @(negedge clk_in);
    endtask
    // outputs whose clock comes from loop l
    function automatic logic [7:0] loop_set(input logic l,
        input logic [3:0] lo, input logic [11:0] hi);
        logic [2:0] c;
        loop_set = 8'h00;
        for (int i = 0; i < 4; i++) begin
            c = hi[3*i +: 3];
            loop_set[i] = (lo[i] == l);
            loop_set[i+4] = (c == {2'b00, l}) || (c == 3'h2 && lo[2] == l)
                || (c == 3'h3 && lo[3] == l);
        end
    endfunction
    function automatic logic [7:0] slow_only(input logic [7:0] v,
        input logic [2:0] fast_refs);
        logic [2:0] c;
        slow_only = v & 8'h77;
        for (int k = 0; k < 2; k++) begin
            c = slow_only[4*k +: 3];
            if (c[2] && c != 3'h7 && fast_refs[c[1:0]]) begin
                slow_only[4*k +: 3] = 3'h7;
            end
        end
    endfunction
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'hC653F17A));
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        arst_n_in = 1;
        repeat (4) @(negedge clk_in);
        rd(16'h00A8, 8'h0A);
        rd(16'h00A9, 8'h20);
        rd(16'h00AA, 8'h56);
        wr(16'h00AB, 8'h00);
        rd(16'h00AB, 8'hA0);
        rd(16'h00B0, 8'h00);
        repeat (24) begin
            lowv = $urandom;
            fast = $urandom;
            s45 = slow_only($urandom, fast);
            s67 = slow_only($urandom, fast);
            lp = $urandom;
            wr(16'h00A8, lowv & 8'h0F);
            wr(16'h00A9, s45);
            wr(16'h00AA, s67);
            rd(16'h00AA, s67 & 8'h77);
            chk("low", {8'h00, lowv[3:0]}, {8'h00, low_source_out});
            chk("high", {s67[6:4], s67[2:0], s45[6:4], s45[2:0]},
                high_source_out);
            set_v = loop_set(lp, lowv[3:0],
                {s67[6:4], s67[2:0], s45[6:4], s45[2:0]});
            wr(16'h00A8, {2'b00, lp, ~lp, lowv[3:0]});
            repeat (2) @(negedge clk_in);
            chk("hold", {4'h0, set_v}, {4'h0, divider_hold_out});
            wr(16'h00A9, slow_only(~s45, fast));
            chk("hold", {4'h0, set_v}, {4'h0, divider_hold_out});
            wr(16'h00A8, lowv & 8'h0F);
            @(negedge clk_in);
            chk("hold", 12'h000, {4'h0, divider_hold_out});
            chk("clear", {4'h0, set_v}, {4'h0, coarse_clear_out});
            chk("fine", {10'h000, (set_v[2] | set_v[3]) & lp,
                (set_v[2] | set_v[3]) & ~lp}, {10'h000, fine_load_out});
            @(negedge clk_in);
            chk("clear", 12'h000, {4'h0, coarse_clear_out});
        end
        stop_test();
    end
endmodule // testbench
